// File: iab_pkg.sv
// Input audio bus router: shared constants and types
package iab_pkg;

  // ====================================================================
  // Timing and sizes
  localparam int CLK_MHZ      = 50;
  localparam int STAT_WIN_US  = 1000;
  localparam int STAT_WIN_CYC = STAT_WIN_US * CLK_MHZ;
  localparam int NPATH = 2;
  localparam int NBUS  = 16;
  localparam int NDET  = 32;
  localparam int NSRC  = 52;
  localparam int NPAIR = 8;
  localparam int NANA  = 4;
  localparam int DW    = 24;
  localparam int DLW   = 20;
  localparam int NETW  = 22;
  localparam logic [5:0] SRC_AES = 6'h10;
  localparam logic [5:0] SRC_ANA = 6'h20;
  localparam logic [5:0] SRC_MIX = 6'h24;
  localparam logic [5:0] SRC_END = 6'h34;
  localparam logic [4:0] DET_AES = 5'h10;

  // ====================================================================
  // Payload classification
  localparam logic [1:0]  ST_ABSENT = 2'h0;
  localparam logic [1:0]  ST_PCM    = 2'h1;
  localparam logic [1:0]  ST_FMT_A  = 2'h2;
  localparam logic [1:0]  ST_FMT_B  = 2'h3;
  localparam logic [15:0] PRE_A     = 16'hf872;
  localparam logic [15:0] PRE_B     = 16'h4e1f;
  localparam logic [4:0]  DT_FMT_A  = 5'h01;
  localparam logic [4:0]  DT_FMT_B  = 5'h1c;

  // ====================================================================
  // Gain (dB) and delay (0.01 ms units)
  localparam int GAIN_MIN  = -80;
  localparam int GAIN_MAX  = 20;
  localparam int GAIN_BIAS = 84;
  localparam int GAIN_NORM = 28;
  localparam logic [5:0][15:0] GAIN_MANT = {16'h71cf, 16'h656f, 16'h5a67,
                                            16'h5097, 16'h47cf, 16'h4000};
  localparam int BULK_MIN  = -3300;
  localparam int BULK_MAX  = 300000;

  // ====================================================================
  // Register map and fields
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_IRQ_STAT = 12'h004;
  localparam logic [11:0] REG_IRQ_EN   = 12'h008;
  localparam logic [11:0] REG_IRQ_CLR  = 12'h00c;
  localparam logic [11:0] REG_BULK0    = 12'h010;
  localparam logic [11:0] REG_BULK1    = 12'h014;
  localparam logic [11:0] REG_DST      = 12'h020;
  localparam logic [11:0] REG_DST_END  = 12'h030;
  localparam logic [11:0] BUS_BASE     = 12'h100;
  localparam logic [11:0] BUS_END      = 12'h300;
  localparam logic [3:0]  BUS_CFG      = 4'h0;
  localparam logic [3:0]  BUS_DLY      = 4'h4;
  localparam logic [3:0]  BUS_PEAK     = 4'h8;
  localparam logic [3:0]  BUS_NET      = 4'hc;
  localparam int CTRL_PRESET_BIT = 0;
  localparam int CTRL_SRC_LSB    = 8;
  localparam int CFG_MUTE_BIT    = 8;
  localparam int CFG_INV_BIT     = 9;
  localparam int CFG_GAIN_LSB    = 16;
  localparam logic [7:0] SRC_ON_RST = 8'hff;

  // ====================================================================
  // Types
  typedef enum logic [1:0] {K_EMB, K_AES, K_ANA, K_MIX} iab_kind_e;
  typedef enum logic [1:0] {PS_IDLE, PS_GOT_A, PS_GOT_B} iab_pre_e;
  typedef struct packed {
    logic psel; logic penable; logic pwrite;
    logic [11:0] paddr; logic [31:0] pwdata;
  } iab_apb_req_s;
  typedef struct packed {
    logic pready; logic [31:0] prdata; logic pslverr;
  } iab_apb_rsp_s;
  typedef struct packed {
    logic valid; iab_kind_e kind; logic path; logic [3:0] chan;
    logic pcm_ok; logic [DW-1:0] data;
  } iab_smp_in_s;
  typedef struct packed {
    logic valid; logic path; logic [3:0] chan;
    logic [DW-1:0] data; logic [NETW-1:0] delay;
  } iab_smp_out_s;
  typedef struct packed {
    logic [5:0] sel; logic mute; logic inv; logic [7:0] gain;
    logic [DLW-1:0] dly; logic [DW-2:0] peak;
  } iab_bus_s;
  typedef iab_bus_s [NBUS-1:0] iab_path_cfg_t;
  typedef struct packed {
    iab_apb_rsp_s rsp;
    logic [NPAIR-1:0] src_on;
    logic [NPAIR-1:0] src_en;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic irq;
    logic [NPATH-1:0][DLW-1:0] bulk;
    iab_path_cfg_t [NPATH-1:0] cfg;
    logic [NPATH-1:0][NSRC-1:0][DW-1:0] lat;
    iab_pre_e [NPATH-1:0][NDET-1:0] stage;
    logic [NPATH-1:0][NDET-1:0][1:0] cmp;
    logic [NPATH-1:0][NDET-1:0][1:0] stat;
    logic [NPATH-1:0][NDET-1:0] seen;
    logic [23:0] win;
    logic [4:0] rr;
    iab_smp_out_s out;
  } iab_state_s;

endpackage : iab_pkg

// File: iab_top.sv
// Input audio bus router: status, converter control and bus crosspoint
`timescale 1ns/1ps
// What this block does
// - No recognised PCM reports channel absent
// - Recognised PCM reports PCM present
// - Compressed formats flagged only on valid framing
// - Direct discrete route bypasses rate converter
// - Converter disabled when compressed pair detected
// - Preset routes embedded 1-16 to bus 1-16
// - Sources: embedded, discrete, analog, mix nodes
// - Embedded sources only from own path
// - Per channel mute, invert, gain, post-gain meter
// - Gain -80 to +20 dB, 1 dB steps
// - Compressed data intact only at 0 dB
// - Bulk delay adds to video tracking delay
// - Bulk delay -33 to +3000 ms, 0.01 ms
// - Per channel delay offsets, net delay readable
// - Two paths in one block, own config and status; discrete, analog and mix sources shared
module iab_top #(
  parameter int WIN_CYCLES = iab_pkg::STAT_WIN_CYC
) (
  input  wire logic                 mclk_in,
  input  wire logic                 resetn_in,
  input  iab_pkg::iab_apb_req_s     apb_in,
  output iab_pkg::iab_apb_rsp_s     apb_out,
  input  iab_pkg::iab_smp_in_s      smp_in,
  input  wire logic [1:0][19:0]     vid_dly_in,
  output iab_pkg::iab_smp_out_s     smp_out,
  output logic [7:0]                src_en_out,
  output logic                      irq_out
);

  // ==================================================================
  // Elaboration checks
  if (WIN_CYCLES < 2 || WIN_CYCLES > 24'hffffff) begin : g_bad_win
    $error("WIN_CYCLES out of range");
  end

  // ==================================================================
  // State and helpers
  iab_pkg::iab_state_s s_r;
  iab_pkg::iab_state_s s_nxt;
  iab_pkg::iab_bus_s   c_cur;
  logic [23:0]         x_cur;
  logic                op;
  logic [3:0]          ob;
  logic                win_end;
  logic                setup;
  logic                acc;
  logic                wr;

  function automatic iab_pkg::iab_path_cfg_t preset_cfg();
    iab_pkg::iab_path_cfg_t c;
    c = '0;
    for (int b = 0; b < iab_pkg::NBUS; b++) begin
      c[b].sel = 6'(b);
    end
    return c;
  endfunction : preset_cfg

  function automatic iab_pkg::iab_state_s rst_state();
    iab_pkg::iab_state_s t;
    t = '0;
    t.src_on = iab_pkg::SRC_ON_RST;
    t.src_en = iab_pkg::SRC_ON_RST;
    for (int p = 0; p < iab_pkg::NPATH; p++) begin
      t.cfg[p] = preset_cfg();
    end
    return t;
  endfunction : rst_state

  localparam iab_pkg::iab_state_s ST_RST = rst_state();

  // Mantissa per dB mod 6, shift per 6 dB; 6 dB taken as x2 (small error)
  function automatic logic [24:0] gain_apply(input logic [23:0] x, input logic [7:0] g);
    int idx;
    logic signed [63:0] w;
    idx = int'($signed(g)) + iab_pkg::GAIN_BIAS;
    w = 64'($signed(x)) * $signed(64'(iab_pkg::GAIN_MANT[idx % 6]));
    w = (w <<< (idx / 6)) >>> iab_pkg::GAIN_NORM;
    if (w > 64'sh7fffff) begin
      return {1'b1, 24'h7fffff};
    end else if (w < -64'sh800000) begin
      return {1'b1, 24'h800000};
    end
    return {1'b0, w[23:0]};
  endfunction : gain_apply

  function automatic logic [21:0] net_dly(input logic pth, input logic [3:0] bch);
    logic signed [22:0] t;
    // bulk on top of video delay
    t = $signed({3'h0, vid_dly_in[pth]}) + 23'($signed(s_r.bulk[pth]))
        + 23'($signed(s_r.cfg[pth][bch].dly));
    return t[22] ? 22'h0 : t[21:0];
  endfunction : net_dly

  assign op      = s_r.rr[4];
  assign ob      = s_r.rr[3:0];
  assign c_cur   = s_r.cfg[op][ob];
  assign x_cur   = s_r.lat[op][c_cur.sel];
  assign win_end = (s_r.win == 24'(WIN_CYCLES - 1));
  assign setup   = apb_in.psel & ~apb_in.penable;
  assign acc     = apb_in.psel & apb_in.penable & s_r.rsp.pready;
  assign wr      = acc & apb_in.pwrite & ~s_r.rsp.pslverr;

  // ==================================================================
  // Next state
  always_comb begin
    logic [11:0] off;
    logic        pp;
    logic        pb;
    logic [3:0]  bb;
    logic [31:0] rd;
    logic        err;
    logic        hit_bus;
    logic [3:0]  clr;
    logic [3:0]  ev;
    logic        use_l;
    logic        use_d;
    logic [5:0]  si;
    logic [4:0]  di;
    logic [1:0]  ns;
    logic [24:0] gy;
    logic [23:0] y;
    logic [22:0] mag;
    s_nxt   = s_r;
    off     = apb_in.paddr - iab_pkg::BUS_BASE;
    pp      = off[8];
    bb      = off[7:4];
    pb      = (apb_in.paddr == iab_pkg::REG_BULK1);
    hit_bus = (apb_in.paddr >= iab_pkg::BUS_BASE) && (apb_in.paddr < iab_pkg::BUS_END);
    rd      = '0;
    err     = 1'b0;
    clr     = '0;
    ev      = '0;
    use_l   = 1'b0;
    use_d   = 1'b0;
    si      = '0;
    di      = '0;
    ns      = '0;
    gy      = '0;
    y       = '0;
    mag     = '0;

    // ----- Register read decode
    if (apb_in.paddr[1:0] != 2'h0) begin
      err = 1'b1;
    end else if (apb_in.paddr == iab_pkg::REG_CTRL) begin
      rd[iab_pkg::CTRL_SRC_LSB +: iab_pkg::NPAIR] = s_r.src_on;
    end else if (apb_in.paddr == iab_pkg::REG_IRQ_STAT) begin
      rd[3:0] = s_r.irq_stat;
    end else if (apb_in.paddr == iab_pkg::REG_IRQ_EN) begin
      rd[3:0] = s_r.irq_en;
    end else if (apb_in.paddr == iab_pkg::REG_IRQ_CLR) begin
      rd = '0;
    end else if (apb_in.paddr == iab_pkg::REG_BULK0 || pb) begin
      rd = 32'($signed(s_r.bulk[pb]));
    end else if (apb_in.paddr >= iab_pkg::REG_DST && apb_in.paddr < iab_pkg::REG_DST_END) begin
      rd = s_r.stat[apb_in.paddr[3]][apb_in.paddr[2] * 16 +: 16];
    end else if (hit_bus && off[3:0] == iab_pkg::BUS_CFG) begin
      rd[5:0] = s_r.cfg[pp][bb].sel;
      rd[iab_pkg::CFG_MUTE_BIT] = s_r.cfg[pp][bb].mute;
      rd[iab_pkg::CFG_INV_BIT] = s_r.cfg[pp][bb].inv;
      rd[iab_pkg::CFG_GAIN_LSB +: 8] = s_r.cfg[pp][bb].gain;
    end else if (hit_bus && off[3:0] == iab_pkg::BUS_DLY) begin
      rd = 32'($signed(s_r.cfg[pp][bb].dly));
    end else if (hit_bus && off[3:0] == iab_pkg::BUS_PEAK) begin
      rd[22:0] = s_r.cfg[pp][bb].peak;
    end else if (hit_bus && off[3:0] == iab_pkg::BUS_NET) begin
      rd[21:0] = net_dly(pp, bb);
    end else begin
      err = 1'b1;
    end
    // Answer is registered in setup, so the access phase is always one cycle
    s_nxt.rsp.pready = setup;
    if (setup) begin
      s_nxt.rsp.prdata  = rd;
      s_nxt.rsp.pslverr = err;
    end

    // ----- Register writes
    if (wr) begin
      if (apb_in.paddr == iab_pkg::REG_CTRL) begin
        s_nxt.src_on = apb_in.pwdata[iab_pkg::CTRL_SRC_LSB +: iab_pkg::NPAIR];
        if (apb_in.pwdata[iab_pkg::CTRL_PRESET_BIT]) begin
          for (int p = 0; p < iab_pkg::NPATH; p++) begin
            s_nxt.cfg[p] = preset_cfg();
          end
        end
      end else if (apb_in.paddr == iab_pkg::REG_IRQ_EN) begin
        s_nxt.irq_en = apb_in.pwdata[3:0];
      end else if (apb_in.paddr == iab_pkg::REG_IRQ_CLR) begin
        clr = apb_in.pwdata[3:0];
      end else if (apb_in.paddr == iab_pkg::REG_BULK0 || pb) begin
        if ($signed(apb_in.pwdata) < iab_pkg::BULK_MIN) begin
          s_nxt.bulk[pb] = 20'(iab_pkg::BULK_MIN);
        end else if ($signed(apb_in.pwdata) > iab_pkg::BULK_MAX) begin
          s_nxt.bulk[pb] = 20'(iab_pkg::BULK_MAX);
        end else begin
          s_nxt.bulk[pb] = apb_in.pwdata[19:0];
        end
      end else if (hit_bus && off[3:0] == iab_pkg::BUS_CFG) begin
        if (apb_in.pwdata[5:0] < iab_pkg::SRC_END) begin
          s_nxt.cfg[pp][bb].sel = apb_in.pwdata[5:0];
        end
        s_nxt.cfg[pp][bb].mute = apb_in.pwdata[iab_pkg::CFG_MUTE_BIT];
        s_nxt.cfg[pp][bb].inv  = apb_in.pwdata[iab_pkg::CFG_INV_BIT];
        if ($signed(apb_in.pwdata[23:16]) < iab_pkg::GAIN_MIN) begin
          s_nxt.cfg[pp][bb].gain = 8'(iab_pkg::GAIN_MIN);
        end else if ($signed(apb_in.pwdata[23:16]) > iab_pkg::GAIN_MAX) begin
          s_nxt.cfg[pp][bb].gain = 8'(iab_pkg::GAIN_MAX);
        end else begin
          s_nxt.cfg[pp][bb].gain = apb_in.pwdata[23:16];
        end
      end else if (hit_bus && off[3:0] == iab_pkg::BUS_DLY) begin
        s_nxt.cfg[pp][bb].dly = apb_in.pwdata[19:0];
      end
    end
    // Meter clears on read
    if (acc && !apb_in.pwrite && hit_bus && off[3:0] == iab_pkg::BUS_PEAK) begin
      s_nxt.cfg[pp][bb].peak = '0;
    end

    // ----- Status window; a sample in the last cycle counts for the next
    s_nxt.win = win_end ? 24'h0 : s_r.win + 24'h1;
    if (win_end) begin
      for (int p = 0; p < iab_pkg::NPATH; p++) begin
        for (int d = 0; d < iab_pkg::NDET; d++) begin
          ns = !s_r.seen[p][d] ? iab_pkg::ST_ABSENT
             : (s_r.cmp[p][d] != 2'h0) ? s_r.cmp[p][d] : iab_pkg::ST_PCM;
          ev[p] = ev[p] | (ns != s_r.stat[p][d]);
          s_nxt.stat[p][d] = ns;
          s_nxt.seen[p][d] = 1'b0;
          s_nxt.cmp[p][d]  = 2'h0;
        end
      end
    end

    // Input samples; each path latches and detects in its own arrays, discrete, analog and mix words go to both
    for (int p = 0; p < iab_pkg::NPATH; p++) begin
      use_l = 1'b0;
      use_d = 1'b0;
      // embedded only from own path
      // Other path's embedded words must not fall through to the mix latches
      if (smp_in.kind == iab_pkg::K_EMB) begin
        si = {2'h0, smp_in.chan};
        di = {1'b0, smp_in.chan};
        use_l = (smp_in.path == 1'(p));
        use_d = use_l;
      end else if (smp_in.kind == iab_pkg::K_AES) begin
        // taps the stream ahead of the converter
        si = iab_pkg::SRC_AES + {2'h0, smp_in.chan};
        di = iab_pkg::DET_AES + {1'b0, smp_in.chan};
        use_l = 1'b1;
        use_d = 1'b1;
      end else if (smp_in.kind == iab_pkg::K_ANA) begin
        si = iab_pkg::SRC_ANA + {2'h0, smp_in.chan};
        use_l = (smp_in.chan < 4'(iab_pkg::NANA));
      end else begin
        si = iab_pkg::SRC_MIX + {2'h0, smp_in.chan};
        use_l = 1'b1;
      end
      if (smp_in.valid && use_l) begin
        s_nxt.lat[p][si] = smp_in.data;
      end
      if (smp_in.valid && use_d) begin
        case (s_r.stage[p][di])
          iab_pkg::PS_IDLE: begin
            if (smp_in.data[23:8] == iab_pkg::PRE_A) begin
              s_nxt.stage[p][di] = iab_pkg::PS_GOT_A;
            end else begin
              s_nxt.seen[p][di] = s_nxt.seen[p][di] | smp_in.pcm_ok;
            end
          end
          iab_pkg::PS_GOT_A: begin
            if (smp_in.data[23:8] == iab_pkg::PRE_B) begin
              s_nxt.stage[p][di] = iab_pkg::PS_GOT_B;
            end else begin
              s_nxt.stage[p][di] = iab_pkg::PS_IDLE;
              s_nxt.seen[p][di] = s_nxt.seen[p][di] | smp_in.pcm_ok;
            end
          end
          default: begin
            if (smp_in.data[12:8] == iab_pkg::DT_FMT_A) begin
              s_nxt.cmp[p][di]  = iab_pkg::ST_FMT_A;
              s_nxt.seen[p][di] = 1'b1;
            end else if (smp_in.data[12:8] == iab_pkg::DT_FMT_B) begin
              s_nxt.cmp[p][di]  = iab_pkg::ST_FMT_B;
              s_nxt.seen[p][di] = 1'b1;
            end
            s_nxt.stage[p][di] = iab_pkg::PS_IDLE;
          end
        endcase
      end
    end

    // ----- Bus channel output, one channel per cycle
    // unity mantissa and shift give exact words at 0 dB
    gy = gain_apply(x_cur, c_cur.gain);
    y  = gy[23:0];
    if (c_cur.inv) begin
      y = (y == 24'h800000) ? 24'h7fffff : 24'(-$signed(y));
    end
    if (c_cur.mute) begin
      y = '0;
    end
    mag = (y == 24'h800000) ? 23'h7fffff : y[23] ? 23'(-$signed(y)) : y[22:0];
    if (mag > s_nxt.cfg[op][ob].peak) begin
      s_nxt.cfg[op][ob].peak = mag;
    end
    ev[2 + int'(op)] = gy[24];
    s_nxt.out.valid  = 1'b1;
    s_nxt.out.path   = op;
    s_nxt.out.chan   = ob;
    s_nxt.out.data   = y;
    s_nxt.out.delay  = net_dly(op, ob);
    s_nxt.rr         = s_r.rr + 5'h1;

    // ----- Converter enables and interrupt
    for (int k = 0; k < iab_pkg::NPAIR; k++) begin
      s_nxt.src_en[k] = s_r.src_on[k] & ~s_r.stat[0][16 + 2 * k][1]
                        & ~s_r.stat[0][17 + 2 * k][1];
    end
    // Set wins over a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign apb_out    = s_r.rsp;
  assign smp_out    = s_r.out;
  assign src_en_out = s_r.src_en;
  assign irq_out    = s_r.irq;

  // ==================================================================
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_absent_report:
    assert property (win_end && !s_r.seen[0][0] |=> s_r.stat[0][0] == iab_pkg::ST_ABSENT)
    else $error("silent channel not absent");
  a_pcm_report:
    assert property (win_end && s_r.seen[0][0] && s_r.cmp[0][0] == 2'h0
                     |=> s_r.stat[0][0] == iab_pkg::ST_PCM)
    else $error("pcm channel not reported");
  a_fmt_detect:
    assert property (smp_in.valid && smp_in.kind == iab_pkg::K_EMB && !smp_in.path
                     && smp_in.chan == 4'h1 && s_r.stage[0][1] == iab_pkg::PS_GOT_B
                     && smp_in.data[12:8] == iab_pkg::DT_FMT_B
                     |=> s_r.cmp[0][1] == iab_pkg::ST_FMT_B)
    else $error("burst type missed");
  a_win_bound:
    assert property (s_r.win < 24'(WIN_CYCLES))
    else $error("status window overran");
  a_src_off:
    assert property (s_r.stat[0][16][1] |=> !src_en_out[0])
    else $error("converter left on for compressed pair");
  a_preset_map:
    assert property (wr && apb_in.paddr == iab_pkg::REG_CTRL && apb_in.pwdata[0]
                     |=> s_r.cfg[1][15].sel == 6'h0f && s_r.cfg[0][3].gain == 8'h0)
    else $error("preset routing wrong");
  a_gain_range:
    assert property ($signed(c_cur.gain) >= iab_pkg::GAIN_MIN
                     && $signed(c_cur.gain) <= iab_pkg::GAIN_MAX)
    else $error("gain outside range");
  a_unity_intact:
    assert property (resetn_in && c_cur.gain == 8'h0 && !c_cur.mute && !c_cur.inv
                     |=> smp_out.data == $past(x_cur) && smp_out.valid)
    else $error("unity gain altered data");
  a_mute_zero:
    assert property (c_cur.mute |=> smp_out.data == 24'h0 && smp_out.chan == $past(ob))
    else $error("muted channel not zero");
  a_bulk_range:
    assert property ($signed(s_r.bulk[0]) >= iab_pkg::BULK_MIN
                     && $signed(s_r.bulk[0]) <= iab_pkg::BULK_MAX)
    else $error("bulk delay outside range");
  a_apb_ready:
    assert property (setup |=> apb_out.pready ##1 (!apb_out.pready || !apb_in.penable))
    else $error("apb answer timing wrong");

endmodule : iab_top

// File: iab_src_model.sv
// Stream source model for the embedded, discrete, analog and mix audio inputs
`timescale 1ns/1ps
module iab_src_model (
  input  wire logic           mclk_in,
  output iab_pkg::iab_smp_in_s smp_out
);
  // ====================================================================
  // Sample strobe
  initial smp_out = '0;
  task automatic send(input iab_pkg::iab_kind_e k, input logic p, input logic [3:0] c,
                      input logic ok, input logic [23:0] d);
    @(posedge mclk_in);
    smp_out <= '{valid: 1'b1, kind: k, path: p, chan: c, pcm_ok: ok, data: d};
    @(posedge mclk_in);
    // Idle data is inverted so a stale word never looks like a fresh one
    smp_out <= '{valid: 1'b0, kind: k, path: p, chan: c, pcm_ok: 1'b0, data: ~d};
  endtask : send
endmodule : iab_src_model

// File: test_input_audio_bus_router.sv
// Self-checking bench for the input audio bus router
`timescale 1ns/1ps
module test_input_audio_bus_router;
  // ====================================================================
  // Signals
  localparam int WIN = 64;
  logic                  mclk_in = 1'b0;
  logic                  resetn_in = 1'b0;
  iab_pkg::iab_apb_req_s apb_in = '0;
  iab_pkg::iab_apb_rsp_s apb_out;
  iab_pkg::iab_smp_in_s  smp_in;
  iab_pkg::iab_smp_out_s smp_out;
  logic [1:0][19:0]      vid_dly_in = {20'd7, 20'd100};
  logic [7:0]            src_en_out;
  logic                  irq_out;
  logic [31:0]           rd;
  logic [23:0]           sd;
  logic                  er;
  int                    err_total = 0;
  int                    checks = 0;
  always #10 mclk_in = ~mclk_in;
  iab_top #(.WIN_CYCLES(WIN)) iab_top_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .apb_in(apb_in), .apb_out(apb_out), .smp_in(smp_in), .vid_dly_in(vid_dly_in),
    .smp_out(smp_out), .src_en_out(src_en_out), .irq_out(irq_out));
  iab_src_model iab_src_model_i (.mclk_in(mclk_in), .smp_out(smp_in));
  // ====================================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge mclk_in);
    apb_in.penable <= 1'b1;
    // No wait count is assumed; only the bound cuts a hang
    do begin
      @(posedge mclk_in);
      n++;
    end while (apb_out.pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd = apb_out.prdata;
    er = apb_out.pslverr;
    apb_in <= '0;
  endtask : apb
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rc
  task automatic smp(input logic p, input logic [3:0] c);
    repeat (34) @(posedge mclk_in);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk_in);
      if (smp_out.valid === 1'b1 && smp_out.path === p && smp_out.chan === c) begin
        sd = smp_out.data;
        return;
      end
    end
    chk("smp_wait", 32'h1, 32'h0);
  endtask : smp
  function automatic logic [11:0] ba(input logic p, input logic [3:0] c, input logic [3:0] o);
    return iab_pkg::BUS_BASE + {3'h0, p, c, o};
  endfunction : ba
  function automatic logic [31:0] cfg(input logic [5:0] s, input logic m, input logic v,
                                      input logic [7:0] g);
    return {8'h0, g, 6'h0, v, m, 2'h0, s};
  endfunction : cfg
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // ====================================================================
  // Tests
  initial begin
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rc(iab_pkg::REG_CTRL, 32'h0000ff00, "ctrl");
    chk("src_en", 32'hff, {24'h0, src_en_out});
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd3, 1'b1, 24'h010000);
    iab_src_model_i.send(iab_pkg::K_EMB, 1'b1, 4'd3, 1'b1, 24'h050000);
    smp(1'b0, 4'd3);
    chk("p0_bus3", 32'h010000, {8'h0, sd});
    smp(1'b1, 4'd3);
    chk("p1_bus3", 32'h050000, {8'h0, sd});
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b0, 8'd6));
    smp(1'b0, 4'd3);
    chk("gain6", 32'h020000, {8'h0, sd});
    apb(1'b0, ba(1'b0, 4'd3, iab_pkg::BUS_PEAK), 32'h0);
    repeat (40) @(posedge mclk_in);
    rc(ba(1'b0, 4'd3, iab_pkg::BUS_PEAK), 32'h020000, "peak");
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b1, 8'd0));
    smp(1'b0, 4'd3);
    chk("invert", 32'hff0000, {8'h0, sd});
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b1, 1'b0, 8'd0));
    smp(1'b0, 4'd3);
    chk("mute", 32'h0, {8'h0, sd});
    iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd3, 1'b1, 24'h400000);
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b0, 8'd20));
    smp(1'b0, 4'd3);
    chk("sat", 32'h7fffff, {8'h0, sd});
    apb(1'b0, iab_pkg::REG_IRQ_STAT, 32'h0);
    chk("clip_stat", 32'h4, rd & 32'h4);
    chk("irq_masked", 32'h0, {31'h0, irq_out});
    apb(1'b1, iab_pkg::REG_IRQ_EN, 32'h4);
    repeat (2) @(posedge mclk_in);
    chk("irq_on", 32'h1, {31'h0, irq_out});
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b0, 8'd0));
    repeat (40) @(posedge mclk_in);
    apb(1'b1, iab_pkg::REG_IRQ_CLR, 32'h4);
    apb(1'b0, iab_pkg::REG_IRQ_STAT, 32'h0);
    chk("clip_clr", 32'h0, rd & 32'h4);
    chk("irq_off", 32'h0, {31'h0, irq_out});
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b0, 8'd30));
    rc(ba(1'b0, 4'd3, iab_pkg::BUS_CFG), cfg(6'd3, 1'b0, 1'b0, 8'd20), "gain_max");
    apb(1'b1, iab_pkg::REG_BULK0, 32'hfffff060);
    rc(iab_pkg::REG_BULK0, 32'hfffff31c, "bulk_min");
    apb(1'b1, ba(1'b1, 4'd0, iab_pkg::BUS_CFG), cfg(6'd0, 1'b0, 1'b0, 8'hb0));
    apb(1'b1, iab_pkg::REG_BULK1, 32'd60000);
    rc(iab_pkg::REG_BULK1, 32'd60000, "bulk_big");
    apb(1'b1, iab_pkg::REG_BULK0, 32'd50);
    apb(1'b1, ba(1'b0, 4'd3, iab_pkg::BUS_DLY), 32'd25);
    repeat (4) @(posedge mclk_in);
    rc(ba(1'b0, 4'd3, iab_pkg::BUS_NET), 32'd175, "net");
    apb(1'b1, ba(1'b0, 4'd5, iab_pkg::BUS_CFG), cfg(6'h21, 1'b0, 1'b0, 8'd0));
    iab_src_model_i.send(iab_pkg::K_ANA, 1'b0, 4'd1, 1'b1, 24'h030000);
    smp(1'b0, 4'd5);
    chk("analog", 32'h030000, {8'h0, sd});
    apb(1'b1, ba(1'b0, 4'd6, iab_pkg::BUS_CFG), cfg(6'h27, 1'b0, 1'b0, 8'd0));
    smp(1'b0, 4'd6);
    chk("mix_clean", 32'h0, {8'h0, sd});
    iab_src_model_i.send(iab_pkg::K_MIX, 1'b1, 4'd3, 1'b0, 24'h060000);
    smp(1'b0, 4'd6);
    chk("mix", 32'h060000, {8'h0, sd});
    apb(1'b1, iab_pkg::REG_CTRL, 32'h0000ff01);
    rc(ba(1'b0, 4'd5, iab_pkg::BUS_CFG), 32'h5, "preset");
    // Sets repeat for over two windows so one window surely holds whole sets
    repeat (2 * WIN) @(posedge mclk_in);
    for (int i = 0; i < 12; i++) begin
      iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd0, 1'b1, 24'h010000);
      iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd1, 1'b0, 24'hf87200);
      iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd1, 1'b0, 24'h4e1f00);
      iab_src_model_i.send(iab_pkg::K_EMB, 1'b0, 4'd1, 1'b0, 24'h001c00);
      iab_src_model_i.send(iab_pkg::K_AES, 1'b0, 4'd0, 1'b0, 24'hf87200);
      iab_src_model_i.send(iab_pkg::K_AES, 1'b0, 4'd0, 1'b0, 24'h4e1f00);
      iab_src_model_i.send(iab_pkg::K_AES, 1'b0, 4'd0, 1'b0, 24'h000100);
    end
    chk("src_off", 32'hfe, {24'h0, src_en_out});
    rc(iab_pkg::REG_DST, 32'hd, "emb_stat");
    rc(iab_pkg::REG_DST + 12'h4, 32'h2, "dis_stat");
    rc(iab_pkg::REG_DST + 12'h8, 32'h0, "p1_emb");
    rc(iab_pkg::REG_DST + 12'hc, 32'h2, "p1_dis");
    apb(1'b1, iab_pkg::REG_CTRL, 32'h0000fc00);
    repeat (2) @(posedge mclk_in);
    chk("src_sw_off", 32'hfc, {24'h0, src_en_out});
    summarize();
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    chk("timeout", 32'h1, 32'h0);
    summarize();
  end
endmodule : test_input_audio_bus_router
